// *** include/adc_ctrl_cfg.svh ***
// Purpose: constants for the current-input converter control block
// Assumes: core_clk at 250 MHz stands in for the system clock
// Notes: capacitances are in tenths of a pF, charge in tenths of a pC
// How it works
// - one range code drives all eight integrators
// - range code selects feedback capacitor and scale
// - diagnostic high at side edge enters test
// - diagnostic high whole period gives zero
// - in test mode each diagnostic rise injects fixed charge packet
// - test mode leaves readout path unchanged
// - shift clock runs apart from conversion clock
// - provide inverted copy of serial output
// - chain input shifts behind own results
// - divider select divides system clock by four
// - side select low integrates B, high A
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
`define RANGE_W 3
`define CAP_W 10
`define FS_W 12
`define PACKET_DPC 16'h006E
`define DIV_W 2
`define DIV_LAST 2'h3
`define CLK_PERIOD_NS 4
`define TEST_MIN_NS 1000
`define TEST_MIN_CYC ((`TEST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_W 9
`define CHARGE_W 16
`define SHIFT_W 8
// positions of the packed pin synchroniser bits
`define SYNC_W 5
`define SYNC_SIDE 0
`define SYNC_TEST 1
`define SYNC_DIV 2
`define SYNC_SERIAL_SHIFT_CLOCK 3
`define SYNC_CHAIN 4
// feedback capacitance per range code, tenths of a pF
`define CAP_R0 10'h01E
`define CAP_R1 10'h07D
`define CAP_R2 10'h0FA
`define CAP_R3 10'h177
`define CAP_R4 10'h1F4
`define CAP_R5 10'h271
`define CAP_R6 10'h2EE
`define CAP_R7 10'h36B
// full scale per range code, tenths of a pC
`define FS_R0 12'h078
`define FS_R1 12'h1F4
`define FS_R2 12'h3E8
`define FS_R3 12'h5DC
`define FS_R4 12'h7D0
`define FS_R5 12'h9C4
`define FS_R6 12'hBB8
`define FS_R7 12'hDAC
`endif

// *** include/adc_ctrl_pkg.sv ***
// Purpose: shared types of the converter control block
// Assumes: constants come from adc_ctrl_cfg.svh
// Notes: no numbers live here
package adc_ctrl_pkg;
	typedef enum logic [1:0] {mode_normal, mode_test, mode_leaving} test_state_t;
	typedef enum logic {side_b, side_a} side_t;
endpackage

// *** rtl/range_decode.sv ***
// Purpose: decode of the range code into capacitance and full scale
// Assumes: pure combinational, one copy feeds every integrator
// Notes: values are typical figures in tenths
`include "adc_ctrl_cfg.svh"
module range_decode (
	input wire logic [`RANGE_W-1:0] code,
	output logic [`CAP_W-1:0] cap_dpf,
	output logic [`FS_W-1:0] fs_dpc
);
	// capacitor table, scale is cap times four (Vref 4 V region)
	always_comb begin
		case (code)
			3'h0: cap_dpf = `CAP_R0;
			3'h1: cap_dpf = `CAP_R1;
			3'h2: cap_dpf = `CAP_R2;
			3'h3: cap_dpf = `CAP_R3;
			3'h4: cap_dpf = `CAP_R4;
			3'h5: cap_dpf = `CAP_R5;
			3'h6: cap_dpf = `CAP_R6;
			default: cap_dpf = `CAP_R7;
		endcase
	end
	// full scale in tenths of a pC
	always_comb begin
		case (code)
			3'h0: fs_dpc = `FS_R0;
			3'h1: fs_dpc = `FS_R1;
			3'h2: fs_dpc = `FS_R2;
			3'h3: fs_dpc = `FS_R3;
			3'h4: fs_dpc = `FS_R4;
			3'h5: fs_dpc = `FS_R5;
			3'h6: fs_dpc = `FS_R6;
			default: fs_dpc = `FS_R7;
		endcase
	end
endmodule // range_decode

// *** rtl/adc_ctrl_inputs.sv ***
// Purpose: pin-level control of range, test mode, clock divider and chain readout
// Assumes: all control pins are asynchronous and pass two flip-flops
// Notes: the shift clock is sampled, not used as a clock, so it must be slow
`include "adc_ctrl_cfg.svh"
module adc_ctrl_inputs (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic range_sel_bit0,
	input wire logic range_sel_bit1,
	input wire logic range_sel_bit2,
	input wire logic integrate_side_select,
	input wire logic test_pin,
	input wire logic sysclk_quarter_divider,
	input wire logic serial_shift_clock,
	input wire logic chain_data_in,
	input wire logic [`SHIFT_W-1:0] result_word,
	input wire logic result_load,
	output logic [`RANGE_W-1:0] range_all,
	output logic [`CAP_W-1:0] cap_dpf,
	output logic [`FS_W-1:0] fs_dpc,
	output logic side_a_active,
	output logic inputs_connected,
	output logic test_active,
	output logic [`CHARGE_W-1:0] test_charge,
	output logic internal_tick,
	output logic serial_data_out,
	output logic serial_data_out_n,
	output logic result_ready_n
);
	logic [1:0] rst_sync_reg; // reset release pair
	logic rst_n; // synchronised reset
	logic [`SYNC_W-1:0] s1_reg; // first stage, read only by second
	logic [`SYNC_W-1:0] s2_reg; // second stage, usable
	logic [`RANGE_W-1:0] r1_reg; // range first stage
	logic [`RANGE_W-1:0] r2_reg; // range second stage
	logic side_d_reg; // previous side select
	logic test_d_reg; // previous diagnostic level
	logic serial_shift_clock_d_reg; // previous shift clock
	adc_ctrl_pkg::test_state_t tstate_reg;
	adc_ctrl_pkg::side_t side_reg;
	logic [`DIV_W-1:0] div_reg; // quarter divider
	logic [`CAP_W-1:0] cap_w;
	logic [`FS_W-1:0] fs_w;
	logic [`CHARGE_W-1:0] charge_reg;
	logic [`SHIFT_W-1:0] shift_reg; // readout chain
	logic side_edge, test_rise, serial_shift_clock_rise;

	// reset is released through two flops
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// two-flop synchronisers for every pin
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 5'h00;
			s2_reg <= 5'h00;
			r1_reg <= 3'h0;
			r2_reg <= 3'h0;
		end else if (clk_en) begin
			s1_reg <= {chain_data_in, serial_shift_clock, sysclk_quarter_divider, test_pin, integrate_side_select};
			s2_reg <= s1_reg;
			r1_reg <= {range_sel_bit2, range_sel_bit1, range_sel_bit0};
			r2_reg <= r1_reg;
		end
	end

	// one code for all integrators on both sides
	assign range_all = r2_reg;
	range_decode u_dec (
		.code(r2_reg),
		.cap_dpf(cap_w),
		.fs_dpc(fs_w)
	);

	// registered decode outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_dpf <= 10'h000;
			fs_dpc <= 12'h000;
		end else if (clk_en) begin
			cap_dpf <= cap_w;
			fs_dpc <= fs_w;
		end
	end

	// edge history
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			side_d_reg <= 1'h0;
			test_d_reg <= 1'h0;
			serial_shift_clock_d_reg <= 1'h0;
		end else if (clk_en) begin
			side_d_reg <= s2_reg[`SYNC_SIDE];
			test_d_reg <= s2_reg[`SYNC_TEST];
			serial_shift_clock_d_reg <= s2_reg[`SYNC_SERIAL_SHIFT_CLOCK];
		end
	end
	assign side_edge = s2_reg[`SYNC_SIDE] ^ side_d_reg;
	assign test_rise = s2_reg[`SYNC_TEST] & ~test_d_reg;
	assign serial_shift_clock_rise = s2_reg[`SYNC_SERIAL_SHIFT_CLOCK] & ~serial_shift_clock_d_reg;

	// active side follows the select level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			side_reg <= adc_ctrl_pkg::side_b;
		end else if (clk_en) begin
			side_reg <= s2_reg[`SYNC_SIDE] ? adc_ctrl_pkg::side_a : adc_ctrl_pkg::side_b;
		end
	end
	assign side_a_active = (side_reg == adc_ctrl_pkg::side_a);

	// test mode entry and exit; the leaving state covers one integration
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tstate_reg <= adc_ctrl_pkg::mode_normal;
		end else if (clk_en) begin
			case (tstate_reg)
				adc_ctrl_pkg::mode_normal: begin
					if (side_edge && s2_reg[`SYNC_TEST]) begin
						tstate_reg <= adc_ctrl_pkg::mode_test;
					end
				end
				adc_ctrl_pkg::mode_test: begin
					if (side_edge && !s2_reg[`SYNC_TEST]) begin
						tstate_reg <= adc_ctrl_pkg::mode_leaving;
					end
				end
				adc_ctrl_pkg::mode_leaving: begin
					if (side_edge) begin
						tstate_reg <= s2_reg[`SYNC_TEST] ? adc_ctrl_pkg::mode_test : adc_ctrl_pkg::mode_normal;
					end
				end
				default: tstate_reg <= adc_ctrl_pkg::mode_normal;
			endcase
		end
	end
	assign test_active = (tstate_reg == adc_ctrl_pkg::mode_test);
	// inputs cut off in test whatever current flows
	assign inputs_connected = (tstate_reg != adc_ctrl_pkg::mode_test);

	// charge packets per integration, cleared at each side edge;
	// a packet landing on the side edge itself opens the new count instead of being lost
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_reg <= 16'h0000;
		end else if (clk_en) begin
			if (side_edge) begin
				charge_reg <= (test_active && test_rise) ? `PACKET_DPC : 16'h0000;
			end else if (test_active && test_rise) begin
				charge_reg <= charge_reg + `PACKET_DPC;
			end
		end
	end
	assign test_charge = charge_reg;

	// divide by four when selected, else every cycle ticks
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 2'h0;
		end else if (clk_en) begin
			div_reg <= s2_reg[`SYNC_DIV] ? div_reg + 2'h1 : 2'h0;
		end
	end
	assign internal_tick = clk_en & (~s2_reg[`SYNC_DIV] | (div_reg == `DIV_LAST));

	// readout shift path on sampled shift clock; chain data follows own bits
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= 8'h00;
			result_ready_n <= 1'h1;
		end else if (clk_en) begin
			if (result_load) begin
				shift_reg <= result_word;
				result_ready_n <= 1'h0;
			end else if (serial_shift_clock_rise) begin
				shift_reg <= {shift_reg[`SHIFT_W-2:0], s2_reg[`SYNC_CHAIN]};
				result_ready_n <= 1'h1;
			end
		end
	end
	assign serial_data_out = shift_reg[`SHIFT_W-1];
	assign serial_data_out_n = ~shift_reg[`SHIFT_W-1];

	// checks on what this block drives, all on core_clk and quiet in reset
	chk_out_inverted: assert property (@(posedge core_clk) disable iff (!rst_n)
		serial_data_out_n == !serial_data_out) else $error("inverted output mismatch");
	chk_test_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && tstate_reg == adc_ctrl_pkg::mode_normal && side_edge && s2_reg[`SYNC_TEST] |=> !inputs_connected)
		else $error("test entry missed");
	chk_packet_add: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && test_active && test_rise && !side_edge |=> charge_reg == $past(charge_reg) + `PACKET_DPC)
		else $error("packet not added");
	chk_packet_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !test_active && !side_edge |=> charge_reg == $past(charge_reg))
		else $error("packet taken outside test mode");
	chk_zero_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && side_edge && !(test_active && test_rise) |=> charge_reg == 16'h0000)
		else $error("charge not cleared");
	chk_side_map: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en ##1 1'b1 |-> side_a_active == $past(s2_reg[`SYNC_SIDE])) else $error("side mismatch");
	chk_range_shared: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en |=> cap_dpf == $past(cap_w)) else $error("range not applied");
	chk_div_tick: assert property (@(posedge core_clk) disable iff (!rst_n)
		s2_reg[`SYNC_DIV] && clk_en && internal_tick ##1 (clk_en && s2_reg[`SYNC_DIV]) [*3] |-> !$past(internal_tick))
		else $error("divider rate wrong");
	chk_div_period: assert property (@(posedge core_clk) disable iff (!rst_n)
		s2_reg[`SYNC_DIV] && clk_en && internal_tick ##1 (clk_en && s2_reg[`SYNC_DIV]) [*4] |-> internal_tick)
		else $error("divider tick missing");
	chk_ready_load: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && result_load |=> !result_ready_n && serial_data_out == $past(result_word[`SHIFT_W-1]))
		else $error("load failed");
	chk_shift_step: assert property (@(posedge core_clk) disable iff (!rst_n)
		clk_en && !result_load && serial_shift_clock_rise |=> serial_data_out == $past(shift_reg[`SHIFT_W-2]))
		else $error("shift step wrong");
	cov_test_enter: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(test_active));
	cov_div_tick: cover property (@(posedge core_clk) disable iff (!rst_n) s2_reg[`SYNC_DIV] && internal_tick);
	cov_packet: cover property (@(posedge core_clk) disable iff (!rst_n) test_active && test_rise);
	cov_shift: cover property (@(posedge core_clk) disable iff (!rst_n) serial_shift_clock_rise && !result_ready_n);
endmodule // adc_ctrl_inputs

// *** verif/converter_controller.sv ***
// Purpose: controller model that drives the converter control pins
// Assumes: tasks are called by the bench, each starts on a core_clk edge
// Notes: pins change only by non-blocking assignment on the rising edge
module converter_controller (
	input wire logic core_clk,
	output logic [2:0] range_code,
	output logic side_sel,
	output logic diag,
	output logic shift_clk,
	output logic chain_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int phase_cyc = 250; // one microsecond at 4 ns
	// quiet pins at time zero, shift clock parked low
	initial begin
		range_code = 3'h0;
		side_sel = 1'b0;
		diag = 1'b0;
		shift_clk = 1'b0;
		chain_bit = 1'b0;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// range moves only between conversions, then is held
	task automatic set_range(input logic [2:0] code);
		@(posedge core_clk);
		range_code <= code;
		wait_cyc(6);
	endtask
	// side edge on the clock edge, a full gap after any strobe
	task automatic flip_side();
		wait_cyc(phase_cyc);
		side_sel <= ~side_sel;
		wait_cyc(6);
	endtask
	task automatic set_diag(input logic v);
		@(posedge core_clk);
		diag <= v;
		wait_cyc(phase_cyc);
	endtask
	// low then high again, both phases at least a microsecond
	task automatic strobe();
		set_diag(1'b0);
		set_diag(1'b1);
	endtask
	// one shift clock pulse, slow enough for the sampled input
	task automatic shift(input logic bit_in);
		@(posedge core_clk);
		chain_bit <= bit_in;
		shift_clk <= 1'b1;
		wait_cyc(8);
		shift_clk <= 1'b0;
		chain_bit <= ~bit_in;
		wait_cyc(8);
	endtask
endmodule // converter_controller

// *** verif/test_adc_ctrl_inputs.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: partner model drives the control pins except divider select, which the bench drives; clk_en drops once to check freezing
// Notes: expected values are in tenths of pF and pC
module test_adc_ctrl_inputs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0] cap_tab [8] = '{10'h01E, 10'h07D, 10'h0FA, 10'h177, 10'h1F4, 10'h271, 10'h2EE, 10'h36B};
	localparam logic [11:0] fs_tab [8] = '{12'h078, 12'h1F4, 12'h3E8, 12'h5DC, 12'h7D0, 12'h9C4, 12'hBB8, 12'hDAC};
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1; // dropped once to check that state freezes
	logic div_sel = 1'b0;
	logic load = 1'b0;
	logic [7:0] word = 8'h00;
	logic [2:0] range_code;
	logic side_sel, diag, shift_clk, chain_bit;
	logic [2:0] range_all;
	logic [9:0] cap_dpf;
	logic [11:0] fs_dpc;
	logic [15:0] test_charge;
	logic side_a_active, inputs_connected, test_active, tick, sdo, sdo_n, ready_n;
	logic [15:0] exp_bits;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	int ticks;
	always #2 core_clk = ~core_clk;
	converter_controller u_ctrl (.core_clk(core_clk), .range_code(range_code), .side_sel(side_sel),
		.diag(diag), .shift_clk(shift_clk), .chain_bit(chain_bit));
	adc_ctrl_inputs u_dut (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .range_sel_bit0(range_code[0]),
		.range_sel_bit1(range_code[1]), .range_sel_bit2(range_code[2]), .integrate_side_select(side_sel),
		.test_pin(diag), .sysclk_quarter_divider(div_sel), .serial_shift_clock(shift_clk),
		.chain_data_in(chain_bit), .result_word(word), .result_load(load), .range_all(range_all),
		.cap_dpf(cap_dpf), .fs_dpc(fs_dpc), .side_a_active(side_a_active), .inputs_connected(inputs_connected),
		.test_active(test_active), .test_charge(test_charge), .internal_tick(tick), .serial_data_out(sdo),
		.serial_data_out_n(sdo_n), .result_ready_n(ready_n));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// count internal ticks over 40 settled cycles
	task automatic count_ticks(input logic div);
		@(posedge core_clk);
		div_sel <= div;
		repeat (6) @(posedge core_clk);
		ticks = 0;
		repeat (40) begin
			@(posedge core_clk);
			#1;
			ticks += (tick === 1'b1) ? 1 : 0;
		end
	endtask
	// hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			u_ctrl.set_range(i[2:0]);
			#1;
			chk("range", 16'(i), 16'(range_all));
			chk("cap", 16'(cap_tab[i]), 16'(cap_dpf));
			chk("scale", 16'(fs_tab[i]), 16'(fs_dpc));
		end
		// enable low: a new range code must not reach the decode until it returns
		@(posedge core_clk);
		clk_en <= 1'b0;
		u_ctrl.set_range(3'h2);
		#1;
		chk("cap_frozen", 16'(cap_tab[7]), 16'(cap_dpf));
		@(posedge core_clk);
		clk_en <= 1'b1;
		repeat (6) @(posedge core_clk);
		#1;
		chk("cap", 16'(cap_tab[2]), 16'(cap_dpf));
		chk("side", 16'h0, 16'(side_a_active));
		count_ticks(1'b0);
		chk("ticks", 16'd40, 16'(ticks));
		count_ticks(1'b1);
		chk("ticks", 16'd10, 16'(ticks));
		u_ctrl.set_diag(1'b1);
		u_ctrl.flip_side();
		#1;
		chk("test", 16'h1, 16'(test_active));
		chk("conn", 16'h0, 16'(inputs_connected));
		chk("side", 16'h1, 16'(side_a_active));
		chk("charge", 16'h0, test_charge);
		for (int k = 1; k <= 2; k++) begin
			u_ctrl.strobe();
			#1;
			chk("charge", 16'(k * 16'h006E), test_charge);
		end
		// readout in test mode, shift clock far slower than core_clk
		@(posedge core_clk);
		word <= 8'hA5;
		load <= 1'b1;
		@(posedge core_clk);
		load <= 1'b0;
		#1;
		chk("ready", 16'h0, 16'(ready_n));
		chk("dout", 16'h1, 16'(sdo));
		chk("dout_n", 16'h0, 16'(sdo_n));
		// own byte first, then the chain bits that entered behind it; mixed bits so a stuck chain shows
		exp_bits = 16'hA53C;
		for (int k = 1; k < 16; k++) begin
			u_ctrl.shift((k <= 8) ? exp_bits[8-k] : 1'b0);
			#1;
			chk("dout", 16'(exp_bits[15-k]), 16'(sdo));
			chk("dout_n", 16'(!exp_bits[15-k]), 16'(sdo_n));
		end
		chk("ready", 16'h1, 16'(ready_n));
		u_ctrl.flip_side();
		#1;
		chk("charge", 16'h0, test_charge);
		// leave test mode: drop the diagnostic pin, let an integration pass
		u_ctrl.set_diag(1'b0);
		u_ctrl.flip_side();
		u_ctrl.flip_side();
		#1;
		chk("test", 16'h0, 16'(test_active));
		chk("conn", 16'h1, 16'(inputs_connected));
		// a strobe in normal mode must add no charge
		u_ctrl.strobe();
		#1;
		chk("charge", 16'h0, test_charge);
		chk("test", 16'h0, 16'(test_active));
		test_done();
	end
endmodule // test_adc_ctrl_inputs
